/* core/sch_pkg.sv */
// Purpose: Constants for the serial channel error flag and start block
// Assumes: Byte-wide register port, 100 MHz clock
// Notes:   Offsets are byte addresses on the register port
package sch_pkg;
  localparam int          NUM_CH         = 2;
  localparam int          ADDR_W         = 20;
  localparam int          DATA_W         = 8;
  // Printed offsets
  localparam logic [19:0] STATUS0_ADDR   = 20'hf0100;
  localparam logic [19:0] STATUS1_ADDR   = 20'hf0102;
  localparam logic [19:0] START_ADDR     = 20'hf0122;
  localparam logic [19:0] ENABLE_ADDR    = 20'hf0120;
  // Offsets without a printed value
  localparam logic [19:0] CLEAR0_ADDR    = 20'hf0108;
  localparam logic [19:0] CLEAR1_ADDR    = 20'hf010a;
  localparam logic [19:0] IRQ_STAT_ADDR  = 20'hf0130;
  localparam logic [19:0] IRQ_MASK_ADDR  = 20'hf0131;
  // Status and clear field positions
  localparam int          OVF_BIT        = 0;
  localparam int          PEF_BIT        = 1;
  localparam int          FEF_BIT        = 2;
  localparam int          BUSY_BIT       = 6;
  // Interrupt status layout: per channel n, bits 3n..3n+2 grouped (framing, parity, overrun)
  localparam int          IRQ_PER_CH     = 3;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_WAIT = 2'b01,
    CH_XFER = 2'b11
  } ch_state_e;
endpackage : sch_pkg

/* core/serial_channel_error_flags_and_start.sv */
// Purpose: Error flags, flag clear and start trigger of two serial channels
// Assumes: Event inputs are one-cycle pulses synchronous to ref_clk_i
// Notes:   Shift engines stay outside; they report events and see state
//
// Functional notes
// RQ1: Writing one to framing clear bit zeroes that framing flag.
// RQ2: Asynchronous reception ending without valid stop bit sets framing flag.
// RQ3: Framing flag exists only on channel one; channel zero lacks it.
// RQ4: Writing one to parity clear bit zeroes that parity flag.
// RQ5: Parity mismatch at asynchronous reception end sets parity flag.
// RQ6: Writing one to overrun clear bit zeroes that overrun flag.
// RQ7: Buffer write over unread data with receive enable sets overrun.
// RQ8: Clocked slave transmit without data in time sets overrun flag.
// RQ9: Writing one to start bit sets enable status, enters wait state.
// RQ10: Start bit clears itself once enable status has become one.
// RQ11: Writing zero to a start bit has no effect.
// RQ12: Software writes the start trigger register only as a whole byte.
// RQ13: Reset clears the start trigger register to zero.
// RQ14: Start register at own address; bits 0,1 per channel, rest zero.
// RQ15: Start during transfer aborts it and returns channel to waiting.
// RQ16: Abort leaves control, shift, pins and error flags unchanged.
// RQ17: Exactly two channels, each with own flags, clears and start bit.
// RQ18: Reads of the flag clear register always return zero.
// RQ19: Flag set in same cycle as its clear wins over the clear.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module serial_channel_error_flags_and_start (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [1:0]  receive_enable_bit_i,
  input  wire logic [1:0]  xfer_begin_i,
  input  wire logic [1:0]  xfer_end_i,
  input  wire logic [1:0]  uart_rx_done_i,
  input  wire logic [1:0]  stop_bit_ok_i,
  input  wire logic [1:0]  parity_mismatch_i,
  input  wire logic [1:0]  buffer_full_i,
  input  wire logic [1:0]  buffer_write_i,
  input  wire logic [1:0]  csi_slave_tx_i,
  input  wire logic [1:0]  tx_data_late_i,
  input  wire logic [1:0]  stop_req_i,
  output logic      [1:0]  channel_enable_status_bit_o,
  output logic      [1:0]  abort_o,
  output logic      [1:0]  busy_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [1:0]  start;
    logic [1:0]  enable;
    logic [1:0]  ovf;
    logic [1:0]  pef;
    logic        fef;
    sch_pkg::ch_state_e [1:0] st;
    logic [5:0]  irq_stat;
    logic [5:0]  irq_mask;
    logic [1:0]  abort;
    logic [7:0]  rdata;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  logic [1:0] set_ovf;
  logic [1:0] set_pef;
  logic       set_fef;
  logic [1:0] clr_ovf;
  logic [1:0] clr_pef;
  logic       clr_fef;
  logic [1:0] start_wr;

  // Per channel event decode
  genvar g;
  generate
    for (g = 0; g < sch_pkg::NUM_CH; g++) begin : g_ch
      logic [19:0] clr_addr;
      assign clr_addr = (g == 0) ? sch_pkg::CLEAR0_ADDR
                                 : sch_pkg::CLEAR1_ADDR;
      // RQ7: overrun on buffer overwrite
      // RQ8: overrun on late slave data
      assign set_ovf[g] = (receive_enable_bit_i[g] & buffer_full_i[g]
                           & buffer_write_i[g])
                          | (csi_slave_tx_i[g] & tx_data_late_i[g]);
      // RQ5: parity check result
      assign set_pef[g] = uart_rx_done_i[g] & parity_mismatch_i[g];
      // RQ6: overrun clear decode
      assign clr_ovf[g] = wr_i & (addr_i == clr_addr)
                          & wdata_i[sch_pkg::OVF_BIT];
      // RQ4: parity clear decode
      assign clr_pef[g] = wr_i & (addr_i == clr_addr)
                          & wdata_i[sch_pkg::PEF_BIT];
      // RQ9: start write per bit
      // RQ11: zero bits ignored
      assign start_wr[g] = wr_i & (addr_i == sch_pkg::START_ADDR)
                           & wdata_i[g];
    end
  endgenerate

  // RQ2: missing stop bit, channel one
  // RQ3: framing flag only on channel one
  assign set_fef = uart_rx_done_i[1] & ~stop_bit_ok_i[1];
  // RQ1: framing clear decode
  assign clr_fef = wr_i & (addr_i == sch_pkg::CLEAR1_ADDR)
                   & wdata_i[sch_pkg::FEF_BIT];

  always_comb begin
    logic [5:0] ev;
    ev     = 6'h00;
    nxt_ff = cur_ff;
    for (int i = 0; i < sch_pkg::NUM_CH; i++) begin
      // RQ19: set beats clear
      // RQ16: flags untouched by abort
      nxt_ff.ovf[i] = set_ovf[i] | (cur_ff.ovf[i] & ~clr_ovf[i]);
      nxt_ff.pef[i] = set_pef[i] | (cur_ff.pef[i] & ~clr_pef[i]);
      nxt_ff.abort[i] = 1'b0;
      // RQ10: trigger self clear
      if (cur_ff.start[i] && cur_ff.enable[i]) begin
        nxt_ff.start[i] = 1'b0;
      end
      if (start_wr[i]) begin
        nxt_ff.start[i] = 1'b1;
      end
      if (stop_req_i[i]) begin
        nxt_ff.enable[i] = 1'b0;
        nxt_ff.st[i]     = sch_pkg::CH_IDLE;
      end
      case (cur_ff.st[i])
        sch_pkg::CH_IDLE: begin
          // RQ9: enable and wait
          if (cur_ff.start[i]) begin
            nxt_ff.enable[i] = 1'b1;
            nxt_ff.st[i]     = sch_pkg::CH_WAIT;
          end
        end
        sch_pkg::CH_WAIT: begin
          if (cur_ff.start[i]) begin
            nxt_ff.enable[i] = 1'b1;
          end else if (xfer_begin_i[i] && !stop_req_i[i]) begin
            nxt_ff.st[i] = sch_pkg::CH_XFER;
          end
        end
        sch_pkg::CH_XFER: begin
          // RQ15: abort to wait
          if (cur_ff.start[i]) begin
            nxt_ff.enable[i] = 1'b1;
            nxt_ff.abort[i]  = 1'b1;
            nxt_ff.st[i]     = sch_pkg::CH_WAIT;
          end else if (xfer_end_i[i] && !stop_req_i[i]) begin
            nxt_ff.st[i] = sch_pkg::CH_WAIT;
          end
        end
        default: begin
          nxt_ff.st[i] = sch_pkg::CH_IDLE;
        end
      endcase
    end
    nxt_ff.fef = set_fef | (cur_ff.fef & ~clr_fef);
    ev = {set_ovf[1], set_pef[1], set_fef, set_ovf[0], set_pef[0], 1'b0};
    // Sticky interrupt status, write one to clear, event wins
    for (int j = 0; j < 6; j++) begin
      nxt_ff.irq_stat[j] = ev[j] | (cur_ff.irq_stat[j]
        & ~(wr_i && addr_i == sch_pkg::IRQ_STAT_ADDR && wdata_i[j]));
    end
    if (wr_i && addr_i == sch_pkg::IRQ_MASK_ADDR) begin
      nxt_ff.irq_mask = wdata_i[5:0];
    end
    // Read data valid only the cycle after the strobe
    nxt_ff.rdata = sch_pkg::RESET_BYTE;
    if (rd_i) begin
      case (addr_i)
        sch_pkg::STATUS0_ADDR: begin
          nxt_ff.rdata = {1'b0, cur_ff.st[0] == sch_pkg::CH_XFER, 4'h0,
                          cur_ff.pef[0], cur_ff.ovf[0]};
        end
        sch_pkg::STATUS1_ADDR: begin
          nxt_ff.rdata = {1'b0, cur_ff.st[1] == sch_pkg::CH_XFER, 3'h0,
                          cur_ff.fef, cur_ff.pef[1], cur_ff.ovf[1]};
        end
        // RQ14: start bits, upper zero
        sch_pkg::START_ADDR: begin
          nxt_ff.rdata = {6'h00, cur_ff.start};
        end
        sch_pkg::ENABLE_ADDR: begin
          nxt_ff.rdata = {6'h00, cur_ff.enable};
        end
        sch_pkg::IRQ_STAT_ADDR: begin
          nxt_ff.rdata = {2'h0, cur_ff.irq_stat};
        end
        sch_pkg::IRQ_MASK_ADDR: begin
          nxt_ff.rdata = {2'h0, cur_ff.irq_mask};
        end
        // RQ18: clear register reads zero
        default: begin
          nxt_ff.rdata = sch_pkg::RESET_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      // RQ13: trigger reset zero
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // RQ17: two channel outputs
  assign channel_enable_status_bit_o = cur_ff.enable;
  assign abort_o                     = cur_ff.abort;
  assign busy_o = {cur_ff.st[1] == sch_pkg::CH_XFER,
                   cur_ff.st[0] == sch_pkg::CH_XFER};
  assign rdata_o = cur_ff.rdata;
  // Level interrupt from unmasked sticky bits
  assign irq_o   = |(cur_ff.irq_stat & cur_ff.irq_mask);

endmodule : serial_channel_error_flags_and_start

/* verif/sch_checker_assertions.sv */
// Purpose: Port checks for the serial error flag and start block
// Assumes: Status reads answer one cycle after the read strobe
// Notes:   Flags are only seen through register reads
`timescale 1ns/1ns
module sch_checker (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [1:0]  receive_enable_bit_i,
  input wire logic [1:0]  uart_rx_done_i,
  input wire logic [1:0]  stop_bit_ok_i,
  input wire logic [1:0]  parity_mismatch_i,
  input wire logic [1:0]  buffer_full_i,
  input wire logic [1:0]  buffer_write_i,
  input wire logic [1:0]  channel_enable_status_bit_o,
  input wire logic [1:0]  abort_o,
  input wire logic [1:0]  busy_o
);
  wire logic wst = wr_i && addr_i == sch_pkg::START_ADDR;
  wire logic rs0 = rd_i && addr_i == sch_pkg::STATUS0_ADDR;
  wire logic rs1 = rd_i && addr_i == sch_pkg::STATUS1_ADDR;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_start_enables: assert property (wst && wdata_i[0] |-> ##2
    channel_enable_status_bit_o[0]) else $error("start did not enable");
  a_abort_xfer: assert property (wst && wdata_i[1] && busy_o[1] |->
    ##2 abort_o[1] && !busy_o[1]) else $error("transfer not aborted");
  a_start_reads: assert property (rd_i && addr_i == sch_pkg::START_ADDR
    |=> rdata_o[7:2] == 6'h00) else $error("start upper bits set");
  a_fef_set: assert property (uart_rx_done_i[1] && !stop_bit_ok_i[1]
    ##1 rs1 |=> rdata_o[sch_pkg::FEF_BIT]) else $error("framing lost");
  a_pef_set: assert property (uart_rx_done_i[1] && parity_mismatch_i[1]
    ##1 rs1 |=> rdata_o[sch_pkg::PEF_BIT]) else $error("parity lost");
  a_ovf_set: assert property (receive_enable_bit_i[0] && buffer_full_i[0]
    && buffer_write_i[0] ##1 rs0 |=> rdata_o[sch_pkg::OVF_BIT])
    else $error("overrun lost");
  a_no_fef_ch0: assert property (rs0 |=> !rdata_o[sch_pkg::FEF_BIT])
    else $error("channel 0 framing bit set");
  a_clear_reads: assert property (rd_i && (addr_i == sch_pkg::CLEAR0_ADDR
    || addr_i == sch_pkg::CLEAR1_ADDR) |=> rdata_o == 8'h00)
    else $error("clear register read nonzero");
endmodule : sch_checker
bind serial_channel_error_flags_and_start sch_checker i_chk (.*);

/* verif/testbench.sv */
// Purpose: Self-checking bench for the serial error flag and start block
// Assumes: Read data stand one cycle after the read strobe
// Notes:   Event pulses are dropped by the next read strobe
`timescale 1ns/1ns
module testbench;
  logic ref_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, irq_o;
  logic [19:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o;
  logic [1:0] receive_enable_bit_i = 2'h3, xfer_begin_i = 0, xfer_end_i = 0;
  logic [1:0] uart_rx_done_i = 0, stop_bit_ok_i = 2'h3, parity_mismatch_i = 0;
  logic [1:0] buffer_full_i = 0, buffer_write_i = 0, csi_slave_tx_i = 0;
  logic [1:0] tx_data_late_i = 0, stop_req_i = 0;
  logic [1:0] channel_enable_status_bit_o, abort_o, busy_o;
  int bad_count = 0, n_checks = 0, cycles = 0;
  serial_channel_error_flags_and_start i_dut (.*);
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Ceiling well above the roughly fifty cycles the tests need
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 0;
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    rd_i <= 1;
    addr_i <= a;
    {uart_rx_done_i, buffer_write_i, tx_data_late_i, xfer_begin_i} <= 0;
    @(posedge ref_clk_i);
    rd_i <= 0;
    #1 chk(rdata_o, exp);
  endtask : rd
  task automatic t_start;
    rd(sch_pkg::START_ADDR, 8'h00);
    wr(sch_pkg::START_ADDR, 8'h03);
    rd(sch_pkg::ENABLE_ADDR, 8'h03);
    rd(sch_pkg::START_ADDR, 8'h00);
    @(posedge ref_clk_i);
    stop_req_i <= 2'h1;
    @(posedge ref_clk_i);
    stop_req_i <= 0;
    wr(sch_pkg::START_ADDR, 8'h00);
    rd(sch_pkg::ENABLE_ADDR, 8'h02);
    $display("test start done");
  endtask : t_start
  task automatic t_flags;
    @(posedge ref_clk_i);
    {uart_rx_done_i, parity_mismatch_i, stop_bit_ok_i} <= 6'h29;
    {csi_slave_tx_i, tx_data_late_i} <= 4'ha;
    rd(sch_pkg::STATUS1_ADDR, 8'h07);
    @(posedge ref_clk_i);
    {buffer_full_i, buffer_write_i} <= 4'h5;
    rd(sch_pkg::STATUS0_ADDR, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wr(sch_pkg::IRQ_MASK_ADDR, 8'h3e);
    rd(sch_pkg::IRQ_STAT_ADDR, 8'h3c);
    chk({7'h00, irq_o}, 8'h01);
    wr(sch_pkg::CLEAR1_ADDR, 8'h07);
    wr(sch_pkg::CLEAR0_ADDR, 8'h01);
    rd(sch_pkg::STATUS1_ADDR, 8'h00);
    rd(sch_pkg::STATUS0_ADDR, 8'h00);
    rd(sch_pkg::CLEAR1_ADDR, 8'h00);
    wr(sch_pkg::IRQ_STAT_ADDR, 8'h3c);
    // Let the clearing edge settle before sampling
    #1;
    chk({7'h00, irq_o}, 8'h00);
    @(posedge ref_clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, sch_pkg::CLEAR1_ADDR, 8'h07};
    uart_rx_done_i <= 2'h2;
    @(posedge ref_clk_i);
    {wr_i, uart_rx_done_i} <= 3'h0;
    rd(sch_pkg::STATUS1_ADDR, 8'h06);
    $display("test flags done");
  endtask : t_flags
  task automatic t_abort;
    @(posedge ref_clk_i);
    xfer_begin_i <= 2'h2;
    rd(sch_pkg::STATUS1_ADDR, 8'h46);
    wr(sch_pkg::START_ADDR, 8'h02);
    rd(sch_pkg::STATUS1_ADDR, 8'h06);
    rd(sch_pkg::ENABLE_ADDR, 8'h02);
    $display("test abort done");
  endtask : t_abort
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1;
    t_start();
    t_flags();
    t_abort();
    print_verdict();
  end
endmodule : testbench
